/* rtl/pfss_pin_mux.sv */
// Pin function select for ports A and B and slew control for port B pins 1 and 3 with a Wishbone register slave
//
// Function
// - slew bits 3:2 set port B pin 3 slew level 0 to 3.
// - slew bits 1:0 set port B pin 1 slew level 0 to 3.
// - slew register bits 7:4 are absent and read zero.
// - port A pin 3 code 01 gives analog and battery sense, else I/O with irq 0.
// - port A pin 2: 01 analog channel 9, 10 reference, else I/O.
// - port A pin 1 code 01 gives protect input 0 and analog 10.
// - port A pin 0 code 01 gives protect input 1 and analog 11.
// - port A pin 7 code 01 gives analog 6, else I/O with irq 2.
// - port A pin 6 code 01 gives analog 7, else I/O with irq 1.
// - port A pin 5: 01 timer out, 10 serial data out, 11 undefined.
// - port A pin 4: 01 timer out, 10 serial data in, 11 undefined.
// - port B select bits 7 to 4 give segment commons 3 to 0.
// - port B select bits 3 to 0 give driver 1L, 1H, 0L, 0H.
// - general I/O direction one is input, zero drives the output latch.
`timescale 1ns/10ps
`include "pfss_defines.svh"

module pfss_pin_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Wishbone slave
    input wire pfss_pkg::pfss_wb_req_t wb_req,
    output pfss_pkg::pfss_wb_rsp_t wb_rsp,
    // General I/O latches and directions
    input wire pfss_pkg::pfss_port_ctl_t porta_ctl,
    input wire pfss_pkg::pfss_port_ctl_t portb_ctl,
    // Peripheral outputs
    input wire pfss_pkg::pfss_periph_out_t periph_out,
    // Port A pins
    input wire logic [7:0] porta_pin_in,
    output logic [7:0] porta_pin_out,
    output logic [7:0] porta_pin_oe_b,
    // Port B pins
    output logic [7:0] portb_pin_out,
    output logic [7:0] portb_pin_oe_b,
    // Slew levels of port B pins 1 and 3
    output logic [1:0] pin1_slew_level,
    output logic [1:0] pin3_slew_level,
    // Routed inputs to peripherals
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic ext_irq_two,
    output logic protect_input_zero,
    output logic protect_input_one,
    output logic spi_data_in,
    // Analog switch enables, bit n is channel n; reference and battery sense
    output logic [11:0] analog_channel_en,
    output logic battery_sense_in,
    output logic reference_in_en
);
    import pfss_pkg::*;

    // Selection and slew registers
    logic [7:0] odd_pin_slew_select;
    logic [7:0] porta_low_func_select;
    logic [7:0] porta_high_func_select;
    logic [7:0] portb_func_select;

    // Port A pin synchroniser
    logic [7:0] pa_sync1;
    logic [7:0] pa_sync2;

    // Bus decode and read data
    logic wb_hit;
    logic [31:0] next_rdata;
    logic [7:0] wdata_byte;

    // Port A decode and pin cell outputs
    logic [1:0] porta_pin_func [0:7];
    pfss_func_t pa_fn [0:7];
    logic [7:0] pa_sel;
    logic [7:0] pa_drv;
    logic [7:0] pa_pout;
    logic [7:0] pa_out_c;
    logic [7:0] pa_oe_c;

    // Port B pin cell outputs
    logic [7:0] pb_out_c;
    logic [7:0] pb_oe_c;
    logic [7:0] pb_pout;

    // Decode of a two-bit function field for a given port A pin
    function automatic pfss_func_t pa_decode(input int pin, input logic [1:0] code);
        pfss_func_t fn;
        fn = PFSS_FN_GPIO;
        // Only pins 4 and 5 carry timer and serial functions; only pin 2 has the reference
        case (code)
            `PFSS_CODE_ALT1:
            begin
                if (pin == 4 || pin == 5)
                    fn = PFSS_FN_TIMER;
                else
                    fn = PFSS_FN_ANALOG;
            end
            `PFSS_CODE_ALT2:
            begin
                if (pin == 2)
                    fn = PFSS_FN_REF;
                else if (pin == 4 || pin == 5)
                    fn = PFSS_FN_SPI;
                else
                    fn = PFSS_FN_GPIO;
            end
            `PFSS_CODE_ALT3:
            begin
                if (pin == 4 || pin == 5)
                    fn = PFSS_FN_UNDEF;
                else
                    fn = PFSS_FN_GPIO;
            end
            default: fn = PFSS_FN_GPIO;
        endcase
        return fn;
    endfunction

    // A request is answered once; ack drops in the following cycle
    // Gating on ack keeps a strobe held by the master from being taken twice
    assign wb_hit = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign wdata_byte = wb_req.dat[7:0];

    // Registers written through byte lane 0; reset clears every field
    // A write with lane 0 off is still acknowledged but changes nothing
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            odd_pin_slew_select <= `PFSS_RST_BYTE;
            porta_low_func_select <= `PFSS_RST_BYTE;
            porta_high_func_select <= `PFSS_RST_BYTE;
            portb_func_select <= `PFSS_RST_BYTE;
        end
        else if (wb_hit && wb_req.we && wb_req.sel[0])
        begin
            case (wb_req.adr)
                `PFSS_OFF_SLEW: odd_pin_slew_select <= wdata_byte & `PFSS_SLEW_MASK;
                `PFSS_OFF_PA_LOW: porta_low_func_select <= wdata_byte;
                `PFSS_OFF_PA_HIGH: porta_high_func_select <= wdata_byte;
                `PFSS_OFF_PB: portb_func_select <= wdata_byte;
                default: ;
            endcase
        end
    end

    // Read data mux; unmapped addresses read zero and are still acknowledged
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (wb_req.adr)
            `PFSS_OFF_SLEW: next_rdata[7:0] = odd_pin_slew_select & `PFSS_SLEW_MASK;
            `PFSS_OFF_PA_LOW: next_rdata[7:0] = porta_low_func_select;
            `PFSS_OFF_PA_HIGH: next_rdata[7:0] = porta_high_func_select;
            `PFSS_OFF_PB: next_rdata[7:0] = portb_func_select;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Bus answer one cycle after the request is seen
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_rsp <= '0;
        end
        else
        begin
            wb_rsp.ack <= wb_hit;
            wb_rsp.dat <= wb_hit ? next_rdata : 32'h00000000;
        end
    end

    // Two-stage synchroniser for the port A pin inputs
    // Only the second stage feeds logic; the first may still be settling
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pa_sync1 <= 8'h00;
            pa_sync2 <= 8'h00;
        end
        else
        begin
            pa_sync1 <= porta_pin_in;
            pa_sync2 <= pa_sync1;
        end
    end

    // Per-pin function decode for port A
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pa
            if (gi < 4)
                assign porta_pin_func[gi] = porta_low_func_select[2*gi +: 2];
            else
                assign porta_pin_func[gi] = porta_high_func_select[2*(gi-4) +: 2];
            assign pa_fn[gi] = pa_decode(gi, porta_pin_func[gi]);
            // Undefined code parks the pin as an input with no peripheral attached
            assign pa_sel[gi] = (pa_fn[gi] != PFSS_FN_GPIO);
            assign pa_drv[gi] = (pa_fn[gi] == PFSS_FN_TIMER) || (gi == 5 && pa_fn[gi] == PFSS_FN_SPI);
            assign pa_pout[gi] = (pa_fn[gi] == PFSS_FN_TIMER) ? periph_out.std_timer_output
                                                             : periph_out.spi_data_out;
            pfss_pin_cell u_pa_cell (
                .periph_sel(pa_sel[gi]),
                .periph_drives(pa_drv[gi]),
                .periph_out(pa_pout[gi]),
                .gpio_out(porta_ctl.gpio_out[gi]),
                .gpio_dir(porta_ctl.gpio_dir[gi]),
                .pin_out(pa_out_c[gi]),
                .pin_oe_b(pa_oe_c[gi])
            );
        end
    endgenerate

    // Port B peripheral sources: bits 7..4 segment commons 3..0, bits 3..0 driver outputs
    assign pb_pout = {periph_out.segment_common[3], periph_out.segment_common[2],
                      periph_out.segment_common[1], periph_out.segment_common[0],
                      periph_out.driver1_low_side, periph_out.driver1_high_side,
                      periph_out.driver0_low_side, periph_out.driver0_high_side};

    // Port B selected functions always drive their pins
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pb
            pfss_pin_cell u_pb_cell (
                .periph_sel(portb_func_select[gi]),
                .periph_drives(1'b1),
                .periph_out(pb_pout[gi]),
                .gpio_out(portb_ctl.gpio_out[gi]),
                .gpio_dir(portb_ctl.gpio_dir[gi]),
                .pin_out(pb_out_c[gi]),
                .pin_oe_b(pb_oe_c[gi])
            );
        end
    endgenerate

    // Port A pin drive; reset leaves every pin an undriven input so nothing fights the board
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            porta_pin_out <= 8'h00;
            porta_pin_oe_b <= 8'hFF;
        end
        else
        begin
            porta_pin_out <= pa_out_c;
            porta_pin_oe_b <= pa_oe_c;
        end
    end

    // Port B pin drive, registered like port A
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            portb_pin_out <= 8'h00;
            portb_pin_oe_b <= 8'hFF;
        end
        else
        begin
            portb_pin_out <= pb_out_c;
            portb_pin_oe_b <= pb_oe_c;
        end
    end

    // Slew levels taken straight from the two fields
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin1_slew_level <= 2'h0;
            pin3_slew_level <= 2'h0;
        end
        else
        begin
            pin3_slew_level <= odd_pin_slew_select[`PFSS_PIN3_SLEW_LSB +: 2];
            pin1_slew_level <= odd_pin_slew_select[`PFSS_PIN1_SLEW_LSB +: 2];
        end
    end

    // External interrupt inputs follow their pins only while the pin is general I/O
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_irq_zero <= 1'b0;
            ext_irq_one <= 1'b0;
            ext_irq_two <= 1'b0;
        end
        else
        begin
            ext_irq_zero <= (pa_fn[3] == PFSS_FN_GPIO) && pa_sync2[3];
            ext_irq_one <= (pa_fn[6] == PFSS_FN_GPIO) && pa_sync2[6];
            ext_irq_two <= (pa_fn[7] == PFSS_FN_GPIO) && pa_sync2[7];
        end
    end

    // Protection inputs share pins 1 and 0 with analog channels 10 and 11
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            protect_input_zero <= 1'b0;
            protect_input_one <= 1'b0;
        end
        else
        begin
            protect_input_zero <= (pa_fn[1] == PFSS_FN_ANALOG) && pa_sync2[1];
            protect_input_one <= (pa_fn[0] == PFSS_FN_ANALOG) && pa_sync2[0];
        end
    end

    // Serial data input is held low outside serial mode so a floating pin feeds no noise
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            spi_data_in <= 1'b0;
        end
        else
        begin
            spi_data_in <= (pa_fn[4] == PFSS_FN_SPI) && pa_sync2[4];
        end
    end

    // Analog switch enables, battery sense and reference input
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            analog_channel_en <= 12'h000;
            battery_sense_in <= 1'b0;
            reference_in_en <= 1'b0;
        end
        else
        begin
            analog_channel_en <= {(pa_fn[0] == PFSS_FN_ANALOG), (pa_fn[1] == PFSS_FN_ANALOG),
                                  (pa_fn[2] == PFSS_FN_ANALOG), (pa_fn[3] == PFSS_FN_ANALOG),
                                  (pa_fn[6] == PFSS_FN_ANALOG), (pa_fn[7] == PFSS_FN_ANALOG),
                                  6'h00};
            battery_sense_in <= (pa_fn[3] == PFSS_FN_ANALOG);
            reference_in_en <= (pa_fn[2] == PFSS_FN_REF);
        end
    end

endmodule

/* rtl/pfss_defines.svh */
// Register offsets, field positions, reset values and decode codes of the pin function block
`ifndef PFSS_DEFINES_SVH
`define PFSS_DEFINES_SVH

// Byte addresses of the word registers
`define PFSS_OFF_SLEW 4'h0
`define PFSS_OFF_PA_LOW 4'h4
`define PFSS_OFF_PA_HIGH 4'h8
`define PFSS_OFF_PB 4'hC

// Reset value of every selection and slew register
`define PFSS_RST_BYTE 8'h00

// Implemented bits of the slew register
`define PFSS_SLEW_MASK 8'h0F
`define PFSS_PIN3_SLEW_LSB 2
`define PFSS_PIN1_SLEW_LSB 0

// Two-bit function codes
`define PFSS_CODE_GPIO 2'h0
`define PFSS_CODE_ALT1 2'h1
`define PFSS_CODE_ALT2 2'h2
`define PFSS_CODE_ALT3 2'h3

`endif

/* rtl/pfss_pkg.sv */
// Types shared by the pin function block
package pfss_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pfss_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pfss_wb_rsp_t;

    // Per-pin output latch and direction bits from the general I/O logic
    typedef struct packed {
        logic [7:0] gpio_out;
        logic [7:0] gpio_dir;
    } pfss_port_ctl_t;

    // Peripheral outputs that can reach the pins
    typedef struct packed {
        logic std_timer_output;
        logic spi_data_out;
        logic driver1_low_side;
        logic driver1_high_side;
        logic driver0_low_side;
        logic driver0_high_side;
        logic [3:0] segment_common;
    } pfss_periph_out_t;

    // Decoded function of a port A pin
    typedef enum logic [2:0] {
        PFSS_FN_GPIO,
        PFSS_FN_ANALOG,
        PFSS_FN_REF,
        PFSS_FN_TIMER,
        PFSS_FN_SPI,
        PFSS_FN_UNDEF
    } pfss_func_t;

endpackage

/* rtl/pfss_pin_cell.sv */
// One multiplexed pin: chooses peripheral or general I/O drive and direction
`timescale 1ns/10ps

module pfss_pin_cell (
    // Selection
    input wire logic periph_sel,
    input wire logic periph_drives,
    input wire logic periph_out,
    // General I/O
    input wire logic gpio_out,
    input wire logic gpio_dir,
    // Pin drive
    output logic pin_out,
    output logic pin_oe_b
);

    // Peripheral output replaces the latch; otherwise direction bit 1 means input
    always_comb
    begin
        if (periph_sel)
        begin
            pin_out = periph_drives ? periph_out : 1'b0;
            pin_oe_b = ~periph_drives;
        end
        else
        begin
            pin_out = gpio_out;
            pin_oe_b = gpio_dir;
        end
    end

endmodule

/* testbench/pfss_pin_mux_chk.sv */
// Port assertions of the pin function block
`timescale 1ns/10ps
module pfss_pin_mux_chk (
    // Clock and bus
    input wire logic clock,
    input wire logic rst_b,
    input wire pfss_pkg::pfss_wb_req_t wb_req,
    input wire pfss_pkg::pfss_wb_rsp_t wb_rsp,
    // Pin side
    input wire pfss_pkg::pfss_port_ctl_t porta_ctl,
    input wire pfss_pkg::pfss_port_ctl_t portb_ctl,
    input wire pfss_pkg::pfss_periph_out_t periph_out,
    input wire logic [7:0] porta_pin_out,
    input wire logic [7:0] porta_pin_oe_b,
    input wire logic [7:0] portb_pin_out,
    input wire logic [7:0] portb_pin_oe_b,
    input wire logic [1:0] pin1_slew_level,
    input wire logic [1:0] pin3_slew_level,
    input wire logic [11:0] analog_channel_en,
    input wire logic battery_sense_in,
    input wire logic reference_in_en
);
    import pfss_pkg::*;
    logic [7:0] lo, hi, pb, rd, pa_oe, pa_out, ud;
    logic [3:0] sl;
    logic [1:0] s1, s3;
    logic [11:0] an;
    logic ok, bat, vref;
    wire wr = wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] & ~wb_rsp.ack;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Shadow of the selection registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {lo, hi, pb, sl} <= 28'h0;
            ok <= 1'b0;
        end
        else
        begin
            ok <= 1'b1;
            if (wr && wb_req.adr == 4'h0) sl <= wb_req.dat[3:0];
            if (wr && wb_req.adr == 4'h4) lo <= wb_req.dat[7:0];
            if (wr && wb_req.adr == 4'h8) hi <= wb_req.dat[7:0];
            if (wr && wb_req.adr == 4'hC) pb <= wb_req.dat[7:0];
        end
    end
    // Expected read data, slew and analog switches
    assign rd = wb_req.adr == 4'h0 ? {4'h0, sl} : wb_req.adr == 4'h4 ? lo :
        wb_req.adr == 4'h8 ? hi : wb_req.adr == 4'hC ? pb : 8'h00;
    assign {s3, s1} = sl;
    assign an = {lo[1:0] == 2'h1, lo[3:2] == 2'h1, lo[5:4] == 2'h1, lo[7:6] == 2'h1,
        hi[5:4] == 2'h1, hi[7:6] == 2'h1, 6'h00};
    assign bat = lo[7:6] == 2'h1;
    assign vref = lo[5:4] == 2'h2;
    // Expected port A drive: undriven pins, then peripheral outputs
    always_comb
    begin
        ud = {an[6], an[7], hi[3:2] == 2'h3, hi[1:0] > 2'h1, an[8], lo[5:4] == 2'h2 || an[9], an[10], an[11]};
        pa_oe = ud | (porta_ctl.gpio_dir & {2'h3, hi[3:2] == 2'h0, hi[1:0] != 2'h1, 4'hF});
        pa_out = porta_ctl.gpio_out;
        if (hi[1:0] == 2'h1) pa_out[4] = periph_out.std_timer_output;
        if (hi[3:2] == 2'h1) pa_out[5] = periph_out.std_timer_output;
        if (hi[3:2] == 2'h2) pa_out[5] = periph_out.spi_data_out;
    end
    a_ack_next: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0) else $error("read data without ack");
    a_read_value:
        assert property (wb_rsp.ack && !wb_req.we |-> wb_rsp.dat == {24'h0, rd}) else $error("read data wrong");
    a_slew_pin3: assert property (ok |=> pin3_slew_level == $past(s3)) else $error("pin 3 slew wrong");
    a_slew_pin1: assert property (ok ##1 ok |-> pin1_slew_level == $past(s1)) else $error("pin 1 slew wrong");
    a_portb_route:
        assert property (ok |=> portb_pin_oe_b == $past(~pb & portb_ctl.gpio_dir)
            && portb_pin_out == $past(pb & {periph_out[3:0], periph_out[7:4]} | ~pb & portb_ctl.gpio_out))
        else $error("port B pin drive wrong");
    a_porta_dir:
        assert property (ok |=> porta_pin_oe_b == $past(pa_oe)) else $error("port A enable wrong");
    a_porta_drive:
        assert property (ok |=> ((porta_pin_out ^ $past(pa_out)) & ~porta_pin_oe_b) == 8'h00)
        else $error("port A pin value wrong");
    a_analog_sw:
        assert property (ok |=> analog_channel_en == $past(an) && battery_sense_in == $past(bat)
            && reference_in_en == $past(vref)) else $error("analog switches wrong");
endmodule
bind pfss_pin_mux pfss_pin_mux_chk chk (.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .porta_ctl(porta_ctl), .portb_ctl(portb_ctl), .periph_out(periph_out), .porta_pin_out(porta_pin_out),
    .porta_pin_oe_b(porta_pin_oe_b), .portb_pin_out(portb_pin_out), .portb_pin_oe_b(portb_pin_oe_b),
    .pin1_slew_level(pin1_slew_level), .pin3_slew_level(pin3_slew_level),
    .analog_channel_en(analog_channel_en), .battery_sense_in(battery_sense_in),
    .reference_in_en(reference_in_en));

/* testbench/port_function_select_and_slew_tb.sv */
// Self-checking bench of the pin function block
`timescale 1ns/10ps
module port_function_select_and_slew_tb;
    import pfss_pkg::*;
    logic clock, rst_b, i0, i1, i2, p0, p1, sdi, bat, vref;
    pfss_wb_req_t wb_req;
    pfss_wb_rsp_t wb_rsp;
    pfss_port_ctl_t porta_ctl, portb_ctl;
    pfss_periph_out_t periph_out;
    logic [7:0] pin_in, lo, hi;
    logic [1:0] sl1, sl3;
    logic [11:0] an_en;
    logic [31:0] rdat, d;
    logic [3:0] adrs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    int n_mismatch, tests_run;
    pfss_pin_mux dut (.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .porta_ctl(porta_ctl), .portb_ctl(portb_ctl), .periph_out(periph_out), .porta_pin_in(pin_in),
        .porta_pin_out(), .porta_pin_oe_b(), .portb_pin_out(), .portb_pin_oe_b(),
        .pin1_slew_level(sl1), .pin3_slew_level(sl3), .ext_irq_zero(i0), .ext_irq_one(i1),
        .ext_irq_two(i2), .protect_input_zero(p0), .protect_input_one(p1), .spi_data_in(sdi),
        .analog_channel_en(an_en), .battery_sense_in(bat), .reference_in_en(vref));
    // Expected analog switches
    function automatic logic [31:0] exp_an(input logic [7:0] l, input logic [7:0] h);
        return {20'h0, l[1:0] == 2'h1, l[3:2] == 2'h1, l[5:4] == 2'h1, l[7:6] == 2'h1,
            h[5:4] == 2'h1, h[7:6] == 2'h1, 6'h00};
    endfunction
    // Expected routed inputs: irq 0, 1, 2, protect 0, 1, serial in
    function automatic logic [31:0] exp_rt(input logic [7:0] l, input logic [7:0] h, input logic [7:0] p);
        return {26'h0, p[3] & (l[7:6] != 2'h1), p[6] & (h[5:4] != 2'h1), p[7] & (h[7:6] != 2'h1),
            p[1] & (l[3:2] == 2'h1), p[0] & (l[1:0] == 2'h1), p[4] & (h[1:0] == 2'h2)};
    endfunction
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic bus cycle, held until ack
    task automatic bus(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clock);
        wb_req <= '{1'b1, 1'b1, we, adr, sel, v};
        do
        begin
            @(posedge clock);
            k++;
        end
        while (wb_rsp.ack !== 1'b1 && k < 20);
        rdat = wb_rsp.dat;
        check("ack", 32'h1, {31'h0, wb_rsp.ack});
        wb_req <= '0;
    endtask
    // Counts and verdict
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Clock
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Watchdog
    initial
    begin
        #(20000 * 100);
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        {rst_b, wb_req, porta_ctl, portb_ctl, periph_out, pin_in} = '0;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(18461));
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        foreach (adrs[j])
        begin
            bus(1'b0, adrs[j], 4'hF, 32'h0);
            check("reset read", 32'h0, rdat);
        end
        check("reset slew", 32'h0, {28'h0, sl3, sl1});
        for (int c = 0; c < 4; c++)
        begin
            d = $urandom;
            d[3:0] = {2'(c), ~2'(c)};
            bus(1'b1, 4'h0, 4'hF, d);
            bus(1'b0, 4'h0, 4'hF, 32'h0);
            check("slew read", {28'h0, d[3:0]}, rdat);
            check("pin3 slew", 32'(c), {30'h0, sl3});
            check("pin1 slew", 32'(3 - c), {30'h0, sl1});
        end
        bus(1'b1, 4'h0, 4'hE, 32'h5);
        bus(1'b0, 4'h0, 4'hF, 32'h0);
        check("masked write", 32'hC, rdat);
        for (int i = 0; i < 40; i++)
        begin
            periph_out <= '0;
            lo = (i < 4) ? {4{2'(i)}} : 8'($urandom);
            hi = (i < 4) ? {4{2'(i)}} : 8'($urandom);
            if (i > 3 && i[0]) hi[3:0] = 4'h0;
            bus(1'b1, 4'h4, 4'hF, {24'($urandom), lo});
            bus(1'b1, 4'h8, 4'hF, {24'($urandom), hi});
            bus(1'b1, 4'hC, 4'hF, $urandom);
            porta_ctl <= 16'($urandom);
            portb_ctl <= 16'($urandom);
            periph_out <= 10'($urandom);
            pin_in <= 8'($urandom);
            repeat (5) @(posedge clock);
            @(negedge clock);
            check("analog", exp_an(lo, hi), {20'h0, an_en});
            check("battery", {31'h0, lo[7:6] == 2'h1}, {31'h0, bat});
            check("reference", {31'h0, lo[5:4] == 2'h2}, {31'h0, vref});
            check("routed", exp_rt(lo, hi, pin_in), {26'h0, i0, i1, i2, p0, p1, sdi});
            bus(1'b0, 4'h8, 4'hF, 32'h0);
            check("porta high", {24'h0, hi}, rdat);
        end
        // Reset in mid-run clears every field again
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        bus(1'b0, 4'h4, 4'hF, 32'h0);
        check("reset again", 32'h0, rdat);
        check("slew after reset", 32'h0, {28'h0, sl3, sl1});
        report_and_stop();
    end
endmodule
